/* hw/instrument_status_event_logic.sv */
// status reporting core: standard event and measurement quality groups,
// message-waiting flag, reading halt and error-queue push strobe
// assumes all inputs are one-cycle strobes or levels on sys_clk from the
// command decoder and measurement engine; rst is the power-on reset
`timescale 1ns/1ps
`default_nettype none
module instrument_status_event_logic (
	input wire logic sys_clk,
	input wire logic rst,
	// command decoder strobes
	input wire logic clear_status,
	input wire logic std_event_query,
	input wire logic std_enable_write,
	input wire logic [7:0] std_enable_value,
	input wire logic qual_event_query,
	input wire logic qual_enable_write,
	input wire logic [15:0] qual_enable_value,
	input wire logic status_preset,
	input wire logic opc_executed,
	// non-volatile settings
	input wire logic power_on_clear,
	input wire logic [7:0] std_enable_saved,
	// error sources
	input wire logic query_error,
	input wire logic self_test_fail,
	input wire logic cal_fail,
	input wire logic exec_error,
	input wire logic cmd_error,
	// measurement results
	input wire logic volt_overload,
	input wire logic curr_overload,
	input wire logic ohm_overload,
	input wire logic limit_low_fail,
	input wire logic limit_high_fail,
	// reading and output buffer flow
	input wire logic reading_trigger,
	input wire logic store_to_memory,
	input wire logic all_readings_done,
	input wire logic fetch_transfer,
	input wire logic query_data_loaded,
	input wire logic out_buf_last_read,
	input wire logic out_buf_full,
	// outputs
	output logic [7:0] std_read_data,
	output logic std_read_valid,
	output logic [7:0] std_enable_q,
	output logic [15:0] qual_read_data,
	output logic qual_read_valid,
	output logic [15:0] qual_enable_q,
	output logic [7:0] status_byte_q,
	output logic message_waiting_flag_q,
	output logic halt_readings_q,
	output logic error_log_q
);
	logic [7:0] std_set;
	logic [15:0] qual_set;
	logic [7:0] std_flags;
	logic [15:0] qual_flags;
	logic std_summary;
	logic qual_summary;
	logic any_overload;
	logic restore_pending_q;
	logic restore_pending_d;
	logic std_restore;
	logic std_enable_clear;
	logic message_waiting_flag_d;
	logic halt_readings_d;
	logic error_log_d;
	logic [7:0] status_byte_d;

	always_comb begin
		any_overload = volt_overload | curr_overload | ohm_overload;
		std_set = 8'h00;
		std_set[status_event_pkg::std_opc_bit] = opc_executed;
		std_set[status_event_pkg::std_query_err_bit] = query_error;
		std_set[status_event_pkg::std_device_err_bit] = self_test_fail
			| cal_fail | any_overload;
		std_set[status_event_pkg::std_exec_err_bit] = exec_error;
		std_set[status_event_pkg::std_cmd_err_bit] = cmd_error;
		qual_set = 16'h0000;
		qual_set[status_event_pkg::qual_volt_ovld_bit] = volt_overload;
		qual_set[status_event_pkg::qual_curr_ovld_bit] = curr_overload;
		qual_set[status_event_pkg::qual_ohm_ovld_bit] = ohm_overload;
		qual_set[status_event_pkg::qual_limit_lo_bit] = limit_low_fail;
		qual_set[status_event_pkg::qual_limit_hi_bit] = limit_high_fail;
	end

	// the mask is cleared by reset; one cycle after release the saved copy
	// is put back unless power-on clear is in force
	always_comb begin
		restore_pending_d = 1'b0;
		std_restore = restore_pending_q & ~power_on_clear;
		std_enable_clear = 1'b0;
	end

	event_latch_group #(
		.width(status_event_pkg::std_width),
		.valid_mask(status_event_pkg::std_valid_mask),
		.reset_value(status_event_pkg::std_reset_value),
		.enable_reset(status_event_pkg::std_enable_reset)
	) std_group (
		.sys_clk(sys_clk),
		.rst(rst),
		.event_set(std_set),
		.clear_status(clear_status),
		.event_query(std_event_query),
		.enable_write(std_enable_write),
		.enable_value(std_enable_value),
		.enable_clear(std_enable_clear),
		.enable_restore(std_restore),
		.enable_restore_value(std_enable_saved),
		.flags_q(std_flags),
		.read_data_q(std_read_data),
		.read_valid_q(std_read_valid),
		.enable_q(std_enable_q),
		.summary_q(std_summary)
	);

	event_latch_group #(
		.width(status_event_pkg::qual_width),
		.valid_mask(status_event_pkg::qual_valid_mask),
		.reset_value(status_event_pkg::qual_reset_value),
		.enable_reset(status_event_pkg::qual_enable_reset)
	) qual_group (
		.sys_clk(sys_clk),
		.rst(rst),
		.event_set(qual_set),
		.clear_status(clear_status),
		.event_query(qual_event_query),
		.enable_write(qual_enable_write),
		.enable_value(qual_enable_value),
		.enable_clear(status_preset),
		.enable_restore(1'b0),
		.enable_restore_value(16'h0000),
		.flags_q(qual_flags),
		.read_data_q(qual_read_data),
		.read_valid_q(qual_read_valid),
		.enable_q(qual_enable_q),
		.summary_q(qual_summary)
	);

	always_comb begin
		message_waiting_flag_d = message_waiting_flag_q;
		// last read clears; a new message in the same cycle keeps it set
		if (out_buf_last_read) begin
			message_waiting_flag_d = 1'b0;
		end
		// readings to memory only count once fetched after completion
		if (reading_trigger && !store_to_memory) begin
			message_waiting_flag_d = 1'b1;
		end
		if (fetch_transfer && all_readings_done) begin
			message_waiting_flag_d = 1'b1;
		end
		if (query_data_loaded) begin
			message_waiting_flag_d = 1'b1;
		end
		halt_readings_d = out_buf_full;
		// overloads log nothing; only genuine errors push the queue
		error_log_d = query_error | self_test_fail | cal_fail
			| exec_error | cmd_error;
		status_byte_d = status_event_pkg::stb_reset_value;
		status_byte_d[status_event_pkg::stb_qual_sum_bit] = qual_summary;
		status_byte_d[status_event_pkg::stb_msg_bit] = message_waiting_flag_q;
		status_byte_d[status_event_pkg::stb_std_sum_bit] = std_summary;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			restore_pending_q <= 1'b1;
			message_waiting_flag_q <= 1'b0;
			halt_readings_q <= 1'b0;
			error_log_q <= 1'b0;
			status_byte_q <= status_event_pkg::stb_reset_value;
		end else begin
			restore_pending_q <= restore_pending_d;
			message_waiting_flag_q <= message_waiting_flag_d;
			halt_readings_q <= halt_readings_d;
			error_log_q <= error_log_d;
			status_byte_q <= status_byte_d;
		end
	end
endmodule : instrument_status_event_logic
`default_nettype wire

/* hw/status_event_pkg.sv */
// status event package: bit positions, widths, valid masks, reset values
// assumes a single sys_clk domain and strobes from the command decoder
package status_event_pkg;
	localparam int std_width = 8;
	localparam int qual_width = 16;
	localparam int stb_width = 8;
	// standard event bit positions
	localparam int std_opc_bit = 0;
	localparam int std_query_err_bit = 2;
	localparam int std_device_err_bit = 3;
	localparam int std_exec_err_bit = 4;
	localparam int std_cmd_err_bit = 5;
	localparam int std_power_on_bit = 7;
	// measurement quality bit positions
	localparam int qual_volt_ovld_bit = 0;
	localparam int qual_curr_ovld_bit = 1;
	localparam int qual_ohm_ovld_bit = 9;
	localparam int qual_limit_lo_bit = 11;
	localparam int qual_limit_hi_bit = 12;
	// status byte positions of the summaries
	localparam int stb_qual_sum_bit = 3;
	localparam int stb_msg_bit = 4;
	localparam int stb_std_sum_bit = 5;
	// bits that may ever be set; all others read zero
	localparam logic [7:0] std_valid_mask = 8'hbd;
	localparam logic [15:0] qual_valid_mask = 16'h1a03;
	// power cycle counts as an event: bit 7 set out of reset
	localparam logic [7:0] std_reset_value = 8'h80;
	localparam logic [15:0] qual_reset_value = 16'h0000;
	localparam logic [7:0] std_enable_reset = 8'h00;
	localparam logic [15:0] qual_enable_reset = 16'h0000;
	localparam logic [7:0] stb_reset_value = 8'h00;
endpackage : status_event_pkg

/* hw/event_latch_group.sv */
// one latched event register with its enable mask and summary bit
// assumes set, clear and query strobes are one-cycle pulses on sys_clk
`timescale 1ns/1ps
`default_nettype none
module event_latch_group #(
	parameter int width = 8,
	parameter logic [width-1:0] valid_mask = '1,
	parameter logic [width-1:0] reset_value = '0,
	parameter logic [width-1:0] enable_reset = '0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [width-1:0] event_set,
	input wire logic clear_status,
	input wire logic event_query,
	input wire logic enable_write,
	input wire logic [width-1:0] enable_value,
	input wire logic enable_clear,
	input wire logic enable_restore,
	input wire logic [width-1:0] enable_restore_value,
	output logic [width-1:0] flags_q,
	output logic [width-1:0] read_data_q,
	output logic read_valid_q,
	output logic [width-1:0] enable_q,
	output logic summary_q
);
	logic [width-1:0] flags_d;
	logic [width-1:0] read_data_d;
	logic read_valid_d;
	logic [width-1:0] enable_d;
	logic summary_d;

	always_comb begin
		flags_d = flags_q;
		// query and clear-status both empty the register
		if (clear_status || event_query) begin
			flags_d = '0;
		end
		// latched; a set in the clearing cycle survives
		flags_d = flags_d | (event_set & valid_mask);
		read_data_d = read_data_q;
		if (event_query) begin
			read_data_d = flags_q & valid_mask;
		end
		read_valid_d = event_query;
		enable_d = enable_q;
		if (enable_restore) begin
			enable_d = enable_restore_value;
		end
		if (enable_write) begin
			enable_d = enable_value;
		end
		if (enable_clear) begin
			enable_d = '0;
		end
		// summary follows the latched bits, not latched itself
		summary_d = |(flags_d & enable_d);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags_q <= reset_value;
			read_data_q <= '0;
			read_valid_q <= 1'b0;
			enable_q <= enable_reset;
			summary_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			read_data_q <= read_data_d;
			read_valid_q <= read_valid_d;
			enable_q <= enable_d;
			summary_q <= summary_d;
		end
	end
endmodule : event_latch_group
`default_nettype wire

/* verif/status_cmd_issuer.sv */
// controller model: turns a command code into one strobe for one cycle
// assumes the bench moves go and code only at the falling edge
`timescale 1ns/1ps
`default_nettype none
module status_cmd_issuer (
	input wire logic go,
	input wire logic [2:0] code,
	output logic [6:0] strobe
);
	// one command per cycle, as the parser hands them over
	always_comb begin
		strobe = 7'h00;
		if (go) begin
			strobe[code] = 1'b1;
		end
	end
endmodule : status_cmd_issuer
`default_nettype wire

/* verif/status_event_props.sv */
// checker for the status event core, bound to its top module
// assumes one sys_clk domain and rst as the power-on reset
`timescale 1ns/1ps
`default_nettype none
module status_event_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic std_event_query,
	input wire logic opc_executed,
	input wire logic reading_trigger,
	input wire logic store_to_memory,
	input wire logic out_buf_last_read,
	input wire logic out_buf_full,
	input wire logic cmd_error,
	input wire logic exec_error,
	input wire logic [7:0] std_read_data,
	input wire logic std_read_valid,
	input wire logic [15:0] qual_read_data,
	input wire logic qual_read_valid,
	input wire logic [7:0] status_byte_q,
	input wire logic message_waiting_flag_q,
	input wire logic halt_readings_q,
	input wire logic error_log_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff rst;
	sequence opc_then_query;
		opc_executed ##1 std_event_query;
	endsequence
	AST_OPC_SEEN: assert property (opc_then_query |=> std_read_data[0])
		else $error("completion bit missing from query");
	AST_ERR_LOG: assert property ((cmd_error || exec_error) |=> error_log_q)
		else $error("error without queue push");
	AST_MSG_SET: assert property (reading_trigger && !store_to_memory |=> message_waiting_flag_q)
		else $error("trigger did not raise message flag");
	AST_MSG_HOLD: assert property (message_waiting_flag_q && !out_buf_last_read |=> message_waiting_flag_q)
		else $error("message flag dropped early");
	AST_MSG_BYTE: assert property (message_waiting_flag_q |=> status_byte_q[4])
		else $error("message flag not in status byte");
	AST_HALT: assert property (out_buf_full |=> halt_readings_q)
		else $error("readings not halted on full buffer");
	AST_STB_ZERO: assert property ((status_byte_q & 8'hc7) == 8'h00)
		else $error("unused status byte bit set");
	AST_STD_ZERO: assert property (std_read_valid |-> (std_read_data & 8'h42) == 8'h00)
		else $error("unused standard bit read as one");
	AST_QUAL_ZERO: assert property (qual_read_valid |-> (qual_read_data & 16'he5fc) == 16'h0000)
		else $error("unused quality bit read as one");
endmodule : status_event_props
bind instrument_status_event_logic status_event_props status_event_props_i (
	.sys_clk(sys_clk), .rst(rst), .std_event_query(std_event_query),
	.opc_executed(opc_executed), .reading_trigger(reading_trigger),
	.store_to_memory(store_to_memory), .out_buf_last_read(out_buf_last_read),
	.out_buf_full(out_buf_full), .cmd_error(cmd_error), .exec_error(exec_error),
	.std_read_data(std_read_data), .std_read_valid(std_read_valid),
	.qual_read_data(qual_read_data), .qual_read_valid(qual_read_valid),
	.status_byte_q(status_byte_q), .message_waiting_flag_q(message_waiting_flag_q),
	.halt_readings_q(halt_readings_q), .error_log_q(error_log_q));
`default_nettype wire

/* verif/test_instrument_status_event_logic.sv */
// bench for the status event core: command strobes, events and checks
// assumes the controller model maps codes 0..6 to single strobes
`timescale 1ns/1ps
`default_nettype none
module test_instrument_status_event_logic;
	logic sys_clk, rst, go, power_on_clear, std_read_valid, qual_read_valid;
	logic message_waiting_flag_q, halt_readings_q, error_log_q;
	logic [2:0] code;
	logic [6:0] strobe;
	logic [7:0] std_enable_saved, std_read_data, std_enable_q, status_byte_q;
	logic [15:0] val, qual_read_data, qual_enable_q;
	logic [16:0] ev;
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [7:0] std_exp [10] = '{8'h04, 8'h08, 8'h08, 8'h10, 8'h20,
		8'h08, 8'h08, 8'h08, 8'h00, 8'h00};
	logic [15:0] qual_exp [10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
		16'h0001, 16'h0002, 16'h0200, 16'h0800, 16'h1000};
	status_cmd_issuer status_cmd_issuer_i (.go(go), .code(code), .strobe(strobe));
	instrument_status_event_logic instrument_status_event_logic_i (
		.sys_clk(sys_clk), .rst(rst), .clear_status(strobe[0]),
		.std_event_query(strobe[1]), .qual_event_query(strobe[2]),
		.std_enable_write(strobe[3]), .std_enable_value(val[7:0]),
		.qual_enable_write(strobe[4]), .qual_enable_value(val),
		.status_preset(strobe[5]), .opc_executed(strobe[6]),
		.power_on_clear(power_on_clear), .std_enable_saved(std_enable_saved),
		.query_error(ev[0]), .self_test_fail(ev[1]), .cal_fail(ev[2]),
		.exec_error(ev[3]), .cmd_error(ev[4]), .volt_overload(ev[5]),
		.curr_overload(ev[6]), .ohm_overload(ev[7]), .limit_low_fail(ev[8]),
		.limit_high_fail(ev[9]), .reading_trigger(ev[10]),
		.fetch_transfer(ev[11]), .query_data_loaded(ev[12]),
		.out_buf_last_read(ev[13]), .store_to_memory(ev[14]),
		.all_readings_done(ev[15]), .out_buf_full(ev[16]),
		.std_read_data(std_read_data), .std_read_valid(std_read_valid),
		.std_enable_q(std_enable_q), .qual_read_data(qual_read_data),
		.qual_read_valid(qual_read_valid), .qual_enable_q(qual_enable_q),
		.status_byte_q(status_byte_q), .halt_readings_q(halt_readings_q),
		.message_waiting_flag_q(message_waiting_flag_q), .error_log_q(error_log_q));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// answer is visible at the first falling edge after go rises; the task returns at the second
	task automatic cmd(input logic [2:0] c, input logic [15:0] v);
		code = c;
		val = v;
		go = 1'b1;
		@(negedge sys_clk);
		go = 1'b0;
		@(negedge sys_clk);
	endtask : cmd
	task automatic hit(input int i);
		ev[i] = 1'b1;
		@(negedge sys_clk);
		ev[i] = 1'b0;
		@(negedge sys_clk);
	endtask : hit
	task automatic rd(input logic [2:0] c, input logic [15:0] e);
		code = c;
		val = 16'h0000;
		go = 1'b1;
		@(negedge sys_clk);
		go = 1'b0;
		// valid stands one cycle only, so look before the next edge
		chk((c == 3'h1) ? std_read_valid : qual_read_valid, 16'h0001);
		chk((c == 3'h1) ? {8'h00, std_read_data} : qual_read_data, e);
		@(negedge sys_clk);
	endtask : rd
	task automatic do_reset(input logic poc);
		rst = 1'b1;
		power_on_clear = poc;
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask : do_reset
	initial begin
		{go, code, val, ev} = '0;
		std_enable_saved = 8'h21;
		do_reset(1'b0);
		chk(std_enable_q, 16'h0021);
		rd(3'h1, 16'h0080);
		rd(3'h1, 16'h0000);
		for (int i = 0; i < 10; i++) begin
			ev[i] = 1'b1;
			@(negedge sys_clk);
			ev[i] = 1'b0;
			chk(error_log_q, (i < 5) ? 16'h0001 : 16'h0000);
			repeat (3) @(negedge sys_clk);
			rd(3'h1, std_exp[i]);
			rd(3'h2, qual_exp[i]);
		end
		// completion strobe directly followed by the query
		code = 3'h6;
		val = 16'h0000;
		go = 1'b1;
		@(negedge sys_clk);
		rd(3'h1, 16'h0001);
		hit(4);
		hit(5);
		cmd(3'h0, 16'h0000);
		rd(3'h1, 16'h0000);
		rd(3'h2, 16'h0000);
		cmd(3'h3, 16'h0020);
		hit(4);
		repeat (2) @(negedge sys_clk);
		chk(status_byte_q, 16'h0020);
		rd(3'h1, 16'h0020);
		repeat (2) @(negedge sys_clk);
		chk(status_byte_q, 16'h0000);
		cmd(3'h4, 16'h1000);
		hit(9);
		repeat (2) @(negedge sys_clk);
		chk(status_byte_q, 16'h0008);
		cmd(3'h4, 16'hffff);
		chk(qual_enable_q, 16'hffff);
		cmd(3'h5, 16'h0000);
		chk(qual_enable_q, 16'h0000);
		cmd(3'h3, 16'h0000);
		chk(std_enable_q, 16'h0000);
		hit(10);
		chk(message_waiting_flag_q, 16'h0001);
		hit(13);
		chk(message_waiting_flag_q, 16'h0000);
		// query data placed in the output buffer also raises the flag
		hit(12);
		chk(message_waiting_flag_q, 16'h0001);
		hit(13);
		chk(message_waiting_flag_q, 16'h0000);
		ev[14] = 1'b1;
		hit(10);
		hit(11);
		chk(message_waiting_flag_q, 16'h0000);
		ev[15] = 1'b1;
		hit(11);
		chk(message_waiting_flag_q, 16'h0001);
		ev[16] = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(halt_readings_q, 16'h0001);
		do_reset(1'b1);
		chk(std_enable_q, 16'h0000);
		stop_test();
	end
endmodule : test_instrument_status_event_logic
`default_nettype wire
